// *** common/acs_pkg.sv ***
// Function
// - High result register holds result bits 9..2, bit 9 at bit 7.
// - Low result register holds bits 1..0; its bits 7..2 read zero.
// - Input above upper reference reports FFh high, 03h low, no overflow.
// - Input below lower reference reports zero in both result registers.
// - Setting converter-on starts continuous conversion of the selected input.
// - Clearing converter-on disables the converter and stops any conversion.
// - Each finished conversion sets the completion flag and posts the result unless the result registers are locked or a low read is in flight.
// - Reading high result or writing control/status clears the completion flag.
// - New channel value aborts conversion, clears flag, converts the new input.
// - Reading low result locks both result registers against updates.
// - Lock released by reading high result or clearing converter-on.
// - Clock select slow/fast: 00 half, 01 full, 10 quarter, 11 half.
// - Four-bit channel field is a binary number selecting one of 16 inputs.
// - Wait mode leaves the converter running; halt mode disables it.
// - Control/status resets to 00h; all bits writable except read-only flag.
package acs_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CSR = 8'h45;
    localparam logic [7:0] IDX_RES_HIGH = 8'h46;
    localparam logic [7:0] IDX_RES_LOW = 8'h47;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CSR = {2'h0, IDX_CSR, 2'h0};
    localparam logic [11:0] ADDR_RES_HIGH = {2'h0, IDX_RES_HIGH, 2'h0};
    localparam logic [11:0] ADDR_RES_LOW = {2'h0, IDX_RES_LOW, 2'h0};

    // Control/status field layout
    localparam int EOC_BIT = 7;
    localparam int FAST_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int SLOW_BIT = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;

    // Result layout
    localparam int RES_BITS = 10;
    localparam int HIGH_LSB = 2;
    localparam int LOW_W = 2;
    localparam logic [9:0] CODE_ZERO = 10'h000;

    // Conversion clock terminal counts (divide ratio minus one), selected by {slow, fast}
    localparam logic [1:0] DIV_HALF = 2'h1;
    localparam logic [1:0] DIV_FULL = 2'h0;
    localparam logic [1:0] DIV_QUARTER = 2'h3;

    // Sample phase length in converter clock ticks
    localparam logic [3:0] SAMPLE_TICKS = 4'h3;
    // Highest core clock for the undivided setting
    localparam int FULL_RATE_MAX_HZ = 4_000_000;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT
    } acs_state_e;
endpackage : acs_pkg

// *** verilog/acs_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// Converter clock tick generator; held at zero while stopped
module acs_clk_div (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic slowSel,
    input wire logic fastSel,
    output logic tick
);
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic [1:0] ratio;

    always_comb begin
        unique case ({slowSel, fastSel})
            2'b01: ratio = acs_pkg::DIV_FULL;
            2'b10: ratio = acs_pkg::DIV_QUARTER;
            default: ratio = acs_pkg::DIV_HALF;
        endcase
    end

    // Tick on the last count of each period
    always_comb begin
        tick = run && (count_reg >= ratio);
        if (!run || tick) begin
            count_next = 2'h0;
        end else begin
            count_next = count_reg + 2'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= 2'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : acs_clk_div
`default_nettype wire

// *** verilog/acs_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Converter sequencer with APB register access and digital SAR loop
module acs_control #(
    parameter int ADDR_W = acs_pkg::ADDR_W,
    parameter int RES_BITS = acs_pkg::RES_BITS,
    parameter logic [3:0] SAMPLE_TICKS = acs_pkg::SAMPLE_TICKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic haltMode,
    input wire logic compHigh,
    output logic converterPowerOn,
    output logic sampleHold,
    output logic [3:0] inputSelector,
    output logic [RES_BITS-1:0] trialCode
);
    // Register decode, shared by read and side-effect paths
    function automatic logic [1:0] regDecode(input logic [ADDR_W-1:0] a);
        if (a == acs_pkg::ADDR_CSR) begin
            regDecode = 2'h1;
        end else if (a == acs_pkg::ADDR_RES_HIGH) begin
            regDecode = 2'h2;
        end else if (a == acs_pkg::ADDR_RES_LOW) begin
            regDecode = 2'h3;
        end else begin
            regDecode = 2'h0;
        end
    endfunction : regDecode

    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_CSR = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [1:0] SEL_LOW = 2'h3;

    // Bus state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Control/status state
    logic eoc_reg;
    logic eoc_next;
    logic fast_reg;
    logic fast_next;
    logic on_reg;
    logic on_next;
    logic slow_reg;
    logic slow_next;
    logic [3:0] sel_reg;
    logic [3:0] sel_next;

    // Result state
    logic [7:0] resHigh_reg;
    logic [7:0] resHigh_next;
    logic [1:0] resLow_reg;
    logic [1:0] resLow_next;
    logic lock_reg;
    logic lock_next;

    // Sequencer state
    acs_pkg::acs_state_e state_reg;
    acs_pkg::acs_state_e state_next;
    logic [3:0] sampleCnt_reg;
    logic [3:0] sampleCnt_next;
    logic [3:0] bitIdx_reg;
    logic [3:0] bitIdx_next;
    logic [RES_BITS-1:0] code_reg;
    logic [RES_BITS-1:0] code_next;
    logic hold_reg;
    logic hold_next;
    logic power_reg;
    logic power_next;

    // Decoded bus events
    logic [1:0] regSel;
    logic done;
    logic csrWrite;
    logic highRead;
    logic lowRead;
    logic lowReadPending;
    logic selChange;
    logic run;
    logic tick;
    logic convDone;
    logic [RES_BITS-1:0] finalCode;

    assign regSel = regDecode(paddr);
    // Completion edge of an APB access
    assign done = psel && penable && pready_reg;
    assign csrWrite = done && pwrite && (regSel == SEL_CSR);
    assign highRead = done && !pwrite && (regSel == SEL_HIGH);
    assign lowRead = done && !pwrite && (regSel == SEL_LOW);
    // Low read in its capture or completion cycle; keeps the captured pair coherent
    assign lowReadPending = psel && penable && !pwrite && (regSel == SEL_LOW);
    assign selChange = csrWrite && (pwdata[acs_pkg::SEL_MSB:acs_pkg::SEL_LSB] != sel_reg);
    // halt disables, wait has no effect
    assign run = on_reg && !haltMode;

    // Conversion clock enable
    acs_clk_div acs_clk_div_i (
        .mclk(mclk),
        .rst(rst),
        .run(run),
        .slowSel(slow_reg),
        .fastSel(fast_reg),
        .tick(tick)
    );

    // APB slave: one wait state, data captured before pready rises
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        pslverr_next = pslverr_reg;
        prdata_next = prdata_reg;
        if (psel && penable && !pready_reg) begin
            pslverr_next = (regSel == SEL_NONE);
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                unique case (regSel)
                    SEL_CSR: begin
                        prdata_next[7:0] = {eoc_reg, fast_reg, on_reg, slow_reg, sel_reg};
                    end
                    SEL_HIGH: begin
                        prdata_next[7:0] = resHigh_reg;
                    end
                    SEL_LOW: begin
                        prdata_next[acs_pkg::LOW_W-1:0] = resLow_reg;
                    end
                    SEL_NONE: begin
                        prdata_next = 32'h0000_0000;
                    end
                endcase
            end
        end else if (!psel) begin
            pslverr_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // Control/status register
    always_comb begin
        fast_next = fast_reg;
        on_next = on_reg;
        slow_next = slow_reg;
        sel_next = sel_reg;
        eoc_next = eoc_reg;
        if (convDone) begin
            eoc_next = 1'b1;
        end
        if (highRead) begin
            eoc_next = 1'b0;
        end
        // all bits but the flag writable
        if (csrWrite) begin
            fast_next = pwdata[acs_pkg::FAST_BIT];
            on_next = pwdata[acs_pkg::ON_BIT];
            slow_next = pwdata[acs_pkg::SLOW_BIT];
            sel_next = pwdata[acs_pkg::SEL_MSB:acs_pkg::SEL_LSB];
            eoc_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eoc_reg <= acs_pkg::CSR_RESET[acs_pkg::EOC_BIT];
            fast_reg <= acs_pkg::CSR_RESET[acs_pkg::FAST_BIT];
            on_reg <= acs_pkg::CSR_RESET[acs_pkg::ON_BIT];
            slow_reg <= acs_pkg::CSR_RESET[acs_pkg::SLOW_BIT];
            sel_reg <= acs_pkg::CSR_RESET[acs_pkg::SEL_MSB:acs_pkg::SEL_LSB];
        end else begin
            eoc_reg <= eoc_next;
            fast_reg <= fast_next;
            on_reg <= on_next;
            slow_reg <= slow_next;
            sel_reg <= sel_next;
        end
    end

    // Result registers and read lock
    always_comb begin
        resHigh_next = resHigh_reg;
        resLow_next = resLow_reg;
        lock_next = lock_reg;
        // updates held while locked or low read in flight
        if (convDone && !lock_reg && !lowReadPending) begin
            resHigh_next = finalCode[RES_BITS-1:acs_pkg::HIGH_LSB];
            resLow_next = finalCode[acs_pkg::LOW_W-1:0];
        end
        if (lowRead) begin
            lock_next = 1'b1;
        end
        // unlock on high read or power off
        if (highRead || !on_reg) begin
            lock_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            resHigh_reg <= acs_pkg::RES_RESET;
            resLow_reg <= acs_pkg::RES_RESET[acs_pkg::LOW_W-1:0];
            lock_reg <= 1'b0;
        end else begin
            resHigh_reg <= resHigh_next;
            resLow_reg <= resLow_next;
            lock_reg <= lock_next;
        end
    end

    // Successive approximation: each trial bit kept when input is at or above it.
    // Saturation at both ends falls out of the search, so no overflow flag.
    // all ones when input above range
    // all zero when input below range
    assign finalCode = compHigh ? code_reg : (code_reg & ~(RES_BITS'(1) << bitIdx_reg));
    assign convDone = (state_reg == acs_pkg::ACS_CONVERT) && tick && (bitIdx_reg == 4'h0)
        && !selChange && !(csrWrite && !pwdata[acs_pkg::ON_BIT]);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        sampleCnt_next = sampleCnt_reg;
        bitIdx_next = bitIdx_reg;
        code_next = code_reg;
        hold_next = 1'b0;
        power_next = run;
        unique case (state_reg)
            acs_pkg::ACS_IDLE: begin
                if (run) begin
                    state_next = acs_pkg::ACS_SAMPLE;
                    sampleCnt_next = 4'h0;
                    hold_next = 1'b1;
                end
            end
            acs_pkg::ACS_SAMPLE: begin
                hold_next = 1'b1;
                if (tick) begin
                    if (sampleCnt_reg == SAMPLE_TICKS - 4'h1) begin
                        state_next = acs_pkg::ACS_CONVERT;
                        hold_next = 1'b0;
                        bitIdx_next = 4'(RES_BITS - 1);
                        code_next = RES_BITS'(1) << (RES_BITS - 1);
                    end else begin
                        sampleCnt_next = sampleCnt_reg + 4'h1;
                    end
                end
            end
            acs_pkg::ACS_CONVERT: begin
                if (tick) begin
                    if (bitIdx_reg == 4'h0) begin
                        state_next = acs_pkg::ACS_SAMPLE;
                        sampleCnt_next = 4'h0;
                        hold_next = 1'b1;
                        code_next = finalCode;
                    end else begin
                        bitIdx_next = bitIdx_reg - 4'h1;
                        code_next = finalCode | (RES_BITS'(1) << (bitIdx_reg - 4'h1));
                    end
                end
            end
        endcase
        // abort and restart on new channel
        if (selChange && run) begin
            state_next = acs_pkg::ACS_SAMPLE;
            sampleCnt_next = 4'h0;
            hold_next = 1'b1;
        end
        if (!run || (csrWrite && !pwdata[acs_pkg::ON_BIT])) begin
            state_next = acs_pkg::ACS_IDLE;
            hold_next = 1'b0;
            code_next = acs_pkg::CODE_ZERO;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= acs_pkg::ACS_IDLE;
            sampleCnt_reg <= 4'h0;
            bitIdx_reg <= 4'h0;
            code_reg <= acs_pkg::CODE_ZERO;
            hold_reg <= 1'b0;
            power_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sampleCnt_reg <= sampleCnt_next;
            bitIdx_reg <= bitIdx_next;
            code_reg <= code_next;
            hold_reg <= hold_next;
            power_reg <= power_next;
        end
    end

    // Outputs straight from flops.
    // channel field drives the mux as a binary number
    // no interrupt output exists; software polls
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign converterPowerOn = power_reg;
    assign sampleHold = hold_reg;
    assign inputSelector = sel_reg;
    assign trialCode = code_reg;
endmodule : acs_control
`default_nettype wire

// *** bench/acs_control_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of bus timing and converter control
module acs_control_chk #(
    parameter int ADDR_W = acs_pkg::ADDR_W,
    parameter int RES_BITS = acs_pkg::RES_BITS,
    parameter logic [3:0] SAMPLE_TICKS = acs_pkg::SAMPLE_TICKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic haltMode,
    input wire logic compHigh,
    input wire logic converterPowerOn,
    input wire logic sampleHold,
    input wire logic [3:0] inputSelector,
    input wire logic [RES_BITS-1:0] trialCode
);
    logic wrCsr;
    logic mapped;
    logic [3:0] wrSel;
    // Completed control write and address decode
    assign wrCsr = psel && penable && pready && pwrite && paddr == acs_pkg::ADDR_CSR;
    assign mapped = paddr inside {acs_pkg::ADDR_CSR, acs_pkg::ADDR_RES_HIGH,
        acs_pkg::ADDR_RES_LOW};
    assign wrSel = pwdata[3:0];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address");
    a_low_zero: assert property (
        pready && !pwrite && paddr == acs_pkg::ADDR_RES_LOW |-> prdata[31:2] == '0)
        else $error("low result upper bits not zero");
    a_read_byte: assert property (pready && !pwrite |-> prdata[31:8] == '0)
        else $error("read data above byte not zero");
    a_sel_load: assert property (wrCsr |=> inputSelector == $past(wrSel))
        else $error("channel output not loaded by write");
    a_sel_cause: assert property (!$stable(inputSelector) |-> $past(wrCsr))
        else $error("channel changed without write");
    a_off_stop: assert property (
        wrCsr && !pwdata[acs_pkg::ON_BIT] |-> ##[1:2] !converterPowerOn)
        else $error("converter still on after off write");
    a_halt_stop: assert property (haltMode |-> ##[1:2] !converterPowerOn)
        else $error("converter on during halt");
    a_hold_drop: assert property ($fell(converterPowerOn) |-> ##[0:2] !sampleHold)
        else $error("sampling goes on after power off");
    a_code_idle: assert property (
        !converterPowerOn && !$past(converterPowerOn) |-> trialCode == '0)
        else $error("trial code not cleared while off");
endmodule : acs_control_chk
bind acs_control acs_control_chk #(
    .ADDR_W(ADDR_W),
    .RES_BITS(RES_BITS),
    .SAMPLE_TICKS(SAMPLE_TICKS)
) acs_control_chk_i (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haltMode(haltMode), .compHigh(compHigh),
    .converterPowerOn(converterPowerOn), .sampleHold(sampleHold),
    .inputSelector(inputSelector), .trialCode(trialCode)
);
`default_nettype wire

// *** bench/acs_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Input mux, sample-hold and comparator facing the sequencer
module acs_analog_model (
    input wire logic converterPowerOn,
    input wire logic sampleHold,
    input wire logic [3:0] inputSelector,
    input wire logic [9:0] trialCode,
    output logic compHigh
);
    logic [9:0] heldLevel = 10'h000;
    // pins only sensed here: no pull-up, no interrupt path
    // binary channel number picks the input
    // Channel 0 sits below ground, 15 above the upper reference
    always @(sampleHold or inputSelector) begin
        if (sampleHold) begin
            heldLevel = (inputSelector == 4'h0) ? 10'h000 :
                (inputSelector == 4'hf) ? 10'h3ff : {inputSelector, 6'h2a};
        end
    end
    // Dead core never reports high, so stray ticks give zeros
    assign compHigh = converterPowerOn && heldLevel >= trialCode;
endmodule : acs_analog_model
`default_nettype wire

// *** bench/test_adc_sequencer_control.sv ***
`timescale 1ns/1ps
`default_nettype none
// Register-level test of the converter sequencer
module test_adc_sequencer_control;
    localparam int CONV = int'(acs_pkg::SAMPLE_TICKS) + acs_pkg::RES_BITS;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, haltMode, compHigh;
    logic converterPowerOn, sampleHold, err, lastHold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] inputSelector;
    logic [9:0] trialCode, code;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int lastRise = 0;
    int holdGap = 0;
    int divs[4] = '{2, 1, 4, 2};

    acs_control acs_control_i (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .haltMode(haltMode), .compHigh(compHigh),
        .converterPowerOn(converterPowerOn), .sampleHold(sampleHold),
        .inputSelector(inputSelector), .trialCode(trialCode)
    );
    acs_analog_model acs_analog_model_i (
        .converterPowerOn(converterPowerOn), .sampleHold(sampleHold),
        .inputSelector(inputSelector), .trialCode(trialCode), .compHigh(compHigh)
    );

    // Clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Spacing of sample phases, and a hang guard far above the run length
    always @(posedge mclk) begin
        cycles++;
        if (sampleHold === 1'b1 && lastHold !== 1'b1) begin
            holdGap = cycles - lastRise;
            lastRise = cycles;
        end
        lastHold = sampleHold;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkCount(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkCount
    // One bus transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    // Status reads do not clear the flag, so polling is harmless
    task automatic waitFlag();
        rd = 32'h0;
        while (rd[7] !== 1'b1) apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
    endtask : waitFlag
    function automatic logic [9:0] expCode(input logic [3:0] ch);
        if (ch == 4'h0) return 10'h000;
        if (ch == 4'hf) return 10'h3ff;
        return {ch, 6'h2a};
    endfunction : expCode
    // Low byte first so the pair comes from one sample
    task automatic checkResult(input logic [3:0] ch);
        code = expCode(ch);
        apb(1'b0, acs_pkg::ADDR_RES_LOW, 8'h00);
        chk(rd, {30'h0, code[1:0]});
        apb(1'b0, acs_pkg::ADDR_RES_HIGH, 8'h00);
        chk(rd, {24'h0, code[9:2]});
    endtask : checkResult
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        haltMode = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, acs_pkg::ADDR_RES_HIGH, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, acs_pkg::ADDR_RES_LOW, 8'h00);
        chk(rd, 32'h0);
        // Result writes and unmapped writes must be ignored
        apb(1'b1, acs_pkg::ADDR_RES_HIGH, 8'hff);
        apb(1'b0, acs_pkg::ADDR_RES_HIGH, 8'h00);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 8'hff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h0);
        apb(1'b1, acs_pkg::ADDR_CSR, 8'hff);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h7f);
        apb(1'b0, 12'h000, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        done("registers");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, acs_pkg::ADDR_CSR, {1'b0, i[0], 1'b1, i[1], 4'(i + 3)});
            waitFlag();
            checkResult(4'(i + 3));
            waitFlag();
            checkResult(4'(i + 3));
            repeat (CONV * 8) @(posedge mclk);
            chkCount(holdGap, CONV * divs[i]);
        end
        done("clock select");
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h25);
        waitFlag();
        code = expCode(4'h5);
        apb(1'b0, acs_pkg::ADDR_RES_LOW, 8'h00);
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h29);
        waitFlag();
        apb(1'b0, acs_pkg::ADDR_RES_HIGH, 8'h00);
        chk(rd, {24'h0, code[9:2]});
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h29);
        waitFlag();
        checkResult(4'h9);
        apb(1'b0, acs_pkg::ADDR_RES_LOW, 8'h00);
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h09);
        repeat (CONV * 8) @(posedge mclk);
        chk({30'h0, converterPowerOn, sampleHold}, 32'h0);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h09);
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h2f);
        waitFlag();
        checkResult(4'hf);
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h20);
        waitFlag();
        checkResult(4'h0);
        done("lock");
        waitFlag();
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h20);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h20);
        waitFlag();
        apb(1'b1, acs_pkg::ADDR_CSR, 8'h21);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h21);
        waitFlag();
        checkResult(4'h1);
        done("channel");
        haltMode <= 1'b1;
        repeat (CONV * 8) @(posedge mclk);
        chk({31'h0, converterPowerOn}, 32'h0);
        apb(1'b0, acs_pkg::ADDR_CSR, 8'h00);
        chk(rd, 32'h21);
        haltMode <= 1'b0;
        waitFlag();
        checkResult(4'h1);
        done("halt");
        results();
    end
endmodule : test_adc_sequencer_control
`default_nettype wire
